// File: logic/sst_pkg.sv
`default_nettype none
package sst_pkg;
  // Bus geometry
  localparam int unsigned SST_ADDR_W = 18;
  localparam int unsigned SST_DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [15:0] SST_IDX_CTRL = 16'hFFAA;
  localparam logic [15:0] SST_IDX_HOLD = 16'hFFAB;
  localparam logic [15:0] SST_IDX_FLAGS = 16'hFFAC;
  localparam logic [15:0] SST_IDX_ISTAT = 16'hFFAD;
  localparam logic [15:0] SST_IDX_IMASK = 16'hFFAE;
  // Control fields
  localparam int unsigned SST_TE_BIT = 5;
  localparam int unsigned SST_CKS_HI_BIT = 1;
  localparam int unsigned SST_CKS_LO_BIT = 0;
  localparam logic [1:0] SST_CKS_EXT = 2'h0;
  // Flag fields
  localparam int unsigned SST_EMPTY_BIT = 7;
  localparam int unsigned SST_DONE_BIT = 2;
  // Interrupt event positions
  localparam int unsigned SST_EV_EMPTY = 0;
  localparam int unsigned SST_EV_DONE = 1;
  localparam int unsigned SST_EV_N = 2;
  // Values after reset
  localparam logic [7:0] SST_CTRL_RST = 8'h00;
  localparam logic [7:0] SST_HOLD_RST = 8'h00;
  localparam logic [1:0] SST_IRQ_RST = 2'h0;
  // Character length in bits, as a bit counter end value
  localparam logic [3:0] SST_CNT_LAST = 4'h8;
  // Shifter sequencing
  typedef enum logic {
    SST_IDLE = 1'b0,
    SST_SHIFT = 1'b1
  } sst_state_t;
endpackage : sst_pkg
`default_nettype wire

// File: logic/sst_link_if.sv
`default_nettype none
interface sst_link_if;
  logic run;
  logic load;
  logic [7:0] load_data;
  logic fall;
  logic rise;
  logic busy;
  logic done;
  logic sdo;
  modport ctrl (output run, load, load_data, fall, rise,
                input busy, done, sdo);
  modport shift (input run, load, load_data, fall, rise,
                 output busy, done, sdo);
endinterface : sst_link_if
`default_nettype wire

// File: logic/sst_shifter.sv
`default_nettype none
module sst_shifter
  import sst_pkg::*;
(
  // System
  input wire logic pclk,
  input wire logic presetn,
  // Register side
  sst_link_if.shift lnk
);
  sst_state_t state_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic sdo_q;
  logic done_q;

  // Load, eight falling edges, then the rising edge that takes bit 7
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SST_IDLE;
      shift_q <= SST_HOLD_RST;
      cnt_q <= 4'h0;
    end else begin
      case (state_q)
        SST_IDLE: begin
          if (lnk.run && lnk.load) begin // [RULE8]
            state_q <= SST_SHIFT;
            shift_q <= lnk.load_data;
            cnt_q <= 4'h0;
          end
        end
        SST_SHIFT: begin
          if (!lnk.run) begin
            state_q <= SST_IDLE; // Disable aborts the character
          end else if (lnk.fall && cnt_q != SST_CNT_LAST) begin
            shift_q <= {1'b1, shift_q[7:1]}; // [RULE7]
            cnt_q <= cnt_q + 4'h1;
          end else if (lnk.rise && cnt_q == SST_CNT_LAST) begin
            state_q <= SST_IDLE; // [RULE7]
          end
        end
        default: state_q <= SST_IDLE;
      endcase
    end
  end

  // Output bit moves only on a falling edge; idle line is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_q <= 1'b1;
    end else if (!lnk.run || state_q == SST_IDLE) begin
      sdo_q <= 1'b1; // [RULE1]
    end else if (lnk.fall && cnt_q != SST_CNT_LAST) begin
      sdo_q <= shift_q[0]; // [RULE10]
    end
  end

  // One-cycle end of character pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= lnk.run && state_q == SST_SHIFT && lnk.rise &&
                cnt_q == SST_CNT_LAST;
    end
  end

  assign lnk.busy = (state_q == SST_SHIFT);
  assign lnk.done = done_q;
  assign lnk.sdo = sdo_q;

  a_lsb_first: assert property ( // [RULE7]
    @(posedge pclk) disable iff (!presetn)
    lnk.run && lnk.busy && lnk.fall && cnt_q != SST_CNT_LAST
    |=> lnk.sdo == $past(shift_q[0]))
    else $error("bit sent is not the next low bit");

  a_frame_eight: assert property ( // [RULE7]
    @(posedge pclk) disable iff (!presetn)
    lnk.run && lnk.busy && lnk.rise && cnt_q == SST_CNT_LAST
    |=> !lnk.busy && lnk.done)
    else $error("character did not end after eight bits");
endmodule : sst_shifter
`default_nettype wire

// File: logic/sst_tx_top.sv
// Local design decision: register access over APB.
`default_nettype none
// Summary of operation
// RULE1 - Transmit enable bit 5 turns on sending via the serial output pin
// RULE2 - Clock source bits 00 select external shift clock on clock pin
// RULE3 - Eight-bit read/write holding register keeps the next byte
// RULE4 - Empty flag bit 7 is 0 until the byte moves to the shifter
// RULE5 - Complete flag bit 2 is 0 while sending, 1 when finished
// RULE6 - Flags are cleared by writing 0; writing 1 sets nothing
// RULE7 - Characters are exactly eight bits, low bit first
// RULE8 - A free shifter takes the holding byte at once, back to back
// RULE9 - Software checks the empty flag before writing a new byte
// RULE10 - Output bit changes on each falling edge of the shift clock
module sst_tx_top
  import sst_pkg::*;
(
  // System
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SST_ADDR_W-1:0] paddr,
  input wire logic [SST_DATA_W-1:0] pwdata,
  output logic [SST_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial clock pin, always an input; only external clock mode is built
  input wire logic serial_clock_in,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  // Serial data
  output logic serial_out_pin,
  // Interrupt
  output logic irq
);
  sst_link_if lnk ();

  logic sck_s1_q;
  logic sck_s2_q;
  logic sck_s3_q;
  logic [7:0] ctrl_q;
  logic [7:0] hold_q;
  logic empty_q;
  logic done_q;
  logic [SST_EV_N-1:0] istat_q;
  logic [SST_EV_N-1:0] imask_q;
  logic [SST_EV_N-1:0] rd_clr_q;
  logic [SST_DATA_W-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic sck_out_q;
  logic sck_oe_q;

  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic [15:0] idx;
  logic hit_ctrl;
  logic hit_hold;
  logic hit_flags;
  logic hit_istat;
  logic hit_imask;
  logic mapped;
  logic hold_wr;
  logic flags_wr;
  logic move;
  logic done_set;
  logic [SST_EV_N-1:0] ev;
  logic [SST_EV_N-1:0] clr;
  logic [1:0] cks;
  logic [7:0] flags_rd;

  // Bus phase decode
  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign idx = paddr[SST_ADDR_W-1:2];
  assign hit_ctrl = (idx == SST_IDX_CTRL);
  assign hit_hold = (idx == SST_IDX_HOLD);
  assign hit_flags = (idx == SST_IDX_FLAGS);
  assign hit_istat = (idx == SST_IDX_ISTAT);
  assign hit_imask = (idx == SST_IDX_IMASK);
  assign mapped = hit_ctrl || hit_hold || hit_flags || hit_istat ||
                  hit_imask;
  assign hold_wr = wr && hit_hold;
  assign flags_wr = wr && hit_flags;

  // Shifter is fed only when enabled with the external clock selected
  assign cks = {ctrl_q[SST_CKS_HI_BIT], ctrl_q[SST_CKS_LO_BIT]};
  assign lnk.run = ctrl_q[SST_TE_BIT] &&
                   (cks == SST_CKS_EXT); // [RULE1] [RULE2]
  assign move = lnk.run && !lnk.busy && !empty_q; // [RULE8]
  assign lnk.load = move;
  assign lnk.load_data = hold_q;
  // Edges of the synchronised shift clock
  assign lnk.fall = sck_s3_q && !sck_s2_q; // [RULE10]
  assign lnk.rise = !sck_s3_q && sck_s2_q;
  // Completion counts only if no byte waits behind the finished one
  assign done_set = lnk.done && empty_q && !hold_wr;

  // Readable flag byte; other bits read as zero
  always_comb begin
    flags_rd = 8'h00;
    flags_rd[SST_EMPTY_BIT] = empty_q;
    flags_rd[SST_DONE_BIT] = done_q;
  end

  // Shift clock pin sampled by two flops, third one only for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
    end else begin
      sck_s1_q <= serial_clock_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
    end
  end

  // Clock pin stays an input: only the external source is built
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_out_q <= 1'b1;
      sck_oe_q <= 1'b0;
    end else begin
      sck_out_q <= 1'b1;
      sck_oe_q <= 1'b0; // [RULE2]
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= SST_CTRL_RST;
    end else if (wr && hit_ctrl) begin
      ctrl_q <= pwdata[7:0]; // [RULE1] [RULE2]
    end
  end

  // Holding register, always readable and writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= SST_HOLD_RST;
    end else if (hold_wr) begin
      hold_q <= pwdata[7:0]; // [RULE3]
    end
  end

  // Empty flag: a new byte beats a move in the same cycle, since
  // the moved byte is the old one and the new one still waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_q <= 1'b1;
    end else if (hold_wr) begin
      empty_q <= 1'b0; // [RULE4]
    end else if (move) begin
      empty_q <= 1'b1; // [RULE4]
    end else if (flags_wr && !pwdata[SST_EMPTY_BIT]) begin
      empty_q <= 1'b0; // [RULE6]
    end
  end

  // Complete flag: load starts a character, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b1;
    end else if (done_set) begin
      done_q <= 1'b1; // [RULE5]
    end else if (move) begin
      done_q <= 1'b0; // [RULE5]
    end else if (flags_wr && !pwdata[SST_DONE_BIT]) begin
      done_q <= 1'b0; // [RULE6]
    end
  end

  // Interrupt events: byte moved to shifter, transmission completed
  assign ev[SST_EV_EMPTY] = move && !hold_wr;
  assign ev[SST_EV_DONE] = done_set;
  assign clr = (rd && hit_istat) ? rd_clr_q : SST_IRQ_RST;

  // Sticky bits; a read clears only what it returned
  generate
    for (genvar i = 0; i < SST_EV_N; i++) begin : g_istat
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          istat_q[i] <= 1'b0;
        end else if (ev[i]) begin
          istat_q[i] <= 1'b1;
        end else if (clr[i]) begin
          istat_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_q <= SST_IRQ_RST;
    end else if (wr && hit_imask) begin
      imask_q <= pwdata[SST_EV_N-1:0];
    end
  end

  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(istat_q & imask_q);
    end
  end

  // Answer prepared in setup, so access always takes one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      rd_clr_q <= SST_IRQ_RST;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      rd_clr_q <= (setup && !pwrite && hit_istat) ? istat_q : SST_IRQ_RST;
      if (setup && !pwrite) begin
        case (1'b1)
          hit_ctrl: prdata_q <= {24'h000000, ctrl_q};
          hit_hold: prdata_q <= {24'h000000, hold_q}; // [RULE3]
          hit_flags: prdata_q <= {24'h000000, flags_rd}; // [RULE4]
          hit_istat: prdata_q <= {30'h0, istat_q};
          hit_imask: prdata_q <= {30'h0, imask_q};
          default: prdata_q <= '0;
        endcase
      end else begin
        prdata_q <= '0;
      end
    end
  end

  sst_shifter u_shifter (
    .pclk(pclk),
    .presetn(presetn),
    .lnk(lnk.shift)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serial_clock_out = sck_out_q;
  assign serial_clock_oe = sck_oe_q;
  assign serial_out_pin = lnk.sdo;
  assign irq = irq_q;

  // Checks on the register side
  a_hold_write_full: assert property ( // [RULE4]
    @(posedge pclk) disable iff (!presetn)
    hold_wr |=> !empty_q && hold_q == $past(pwdata[7:0]))
    else $error("holding write did not mark byte pending");

  a_move_empties: assert property ( // [RULE8]
    @(posedge pclk) disable iff (!presetn)
    move && !hold_wr |=> empty_q && lnk.busy)
    else $error("move did not empty holding and start shifter");

  a_pending_moves: assert property ( // [RULE8]
    @(posedge pclk) disable iff (!presetn)
    lnk.run && !empty_q && !lnk.busy |=> lnk.busy)
    else $error("free shifter did not take pending byte");

  a_flag_zero_clears: assert property ( // [RULE6]
    @(posedge pclk) disable iff (!presetn)
    flags_wr && !pwdata[SST_DONE_BIT] && !done_set |=> !done_q)
    else $error("write of zero did not clear complete flag");

  a_flag_one_keeps: assert property ( // [RULE6]
    @(posedge pclk) disable iff (!presetn)
    flags_wr && pwdata[SST_EMPTY_BIT] && !empty_q && !move
    |=> !empty_q)
    else $error("write of one set the empty flag");

  a_busy_not_done: assert property ( // [RULE5]
    @(posedge pclk) disable iff (!presetn)
    move |=> !done_q [*2])
    else $error("complete flag set while sending");

  a_disable_idles: assert property ( // [RULE1]
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q[SST_TE_BIT] |=> ##1 serial_out_pin && !lnk.busy)
    else $error("line not idle with transmit disabled");

  a_internal_clk_off: assert property ( // [RULE2]
    @(posedge pclk) disable iff (!presetn)
    cks != SST_CKS_EXT |=> !lnk.busy && !serial_clock_oe)
    else $error("shifter ran without external clock source");

  a_sdo_on_fall: assert property ( // [RULE10]
    @(posedge pclk) disable iff (!presetn)
    lnk.busy && $past(lnk.busy) && $changed(serial_out_pin)
    |-> $past(lnk.fall))
    else $error("output bit changed without a falling edge");

  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    |(istat_q & imask_q) |=> irq)
    else $error("unmasked status did not raise interrupt");

  c_back_to_back: cover property (
    @(posedge pclk) disable iff (!presetn)
    lnk.done && lnk.load);

  c_complete: cover property (
    @(posedge pclk) disable iff (!presetn)
    done_set);

  c_irq_raised: cover property (
    @(posedge pclk) disable iff (!presetn)
    $rose(irq));

  c_unmapped: cover property (
    @(posedge pclk) disable iff (!presetn)
    access && pslverr);
endmodule : sst_tx_top
`default_nettype wire

// File: tb/sst_master_model.sv
`default_nettype none
module sst_master_model (
  // Link clock and data
  output logic serial_clock,
  input wire logic serial_data,
  // Collected character
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock idles high and runs only inside frames
  initial begin
    serial_clock = 1'b1;
    rx_byte = 8'h00;
  end

  // Falls launch bits, rises sample them; a short count cuts a frame
  task automatic run_frame(input int falls);
    #7; // Keeps link edges away from pclk edges
    for (int i = 0; i < falls; i++) begin
      #160 serial_clock = 1'b0;
      #160 serial_clock = 1'b1;
      rx_byte = {serial_data, rx_byte[7:1]};
    end
  endtask : run_frame
endmodule : sst_master_model
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
module tb
  import sst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [SST_ADDR_W-1:0] paddr;
  logic [SST_DATA_W-1:0] pwdata;
  logic [SST_DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic sclk;
  logic serial_clock_oe;
  logic serial_clock_out;
  logic serial_out_pin;
  logic irq;
  logic [7:0] rx_byte;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int total_checks = 0;

  sst_tx_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clock_in(sclk),
    .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
    .serial_out_pin(serial_out_pin), .irq(irq)
  );

  sst_master_model u_master (
    .serial_clock(sclk), .serial_data(serial_out_pin), .rx_byte(rx_byte)
  );

  // System clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic finish_test();
    $display("Checks %0d, errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd, output logic [31:0] rdat,
                     output logic e);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 16) begin
      fails++;
      $display("ERROR %0t no ready from slave", $time);
      finish_test();
    end
    rdat = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 32'h0, d, e);
    check(d, exp, "read data");
    check({31'h0, e}, 32'h0, "slave error");
  endtask : rd_chk

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({31'h0, serial_out_pin}, 32'h1, "idle line");
    check({31'h0, serial_clock_oe}, 32'h0, "clock pin drive");
    check({31'h0, serial_clock_out}, 32'h1, "clock pin level");
    rd_chk(SST_IDX_CTRL, 32'h0);
    rd_chk(SST_IDX_HOLD, 32'h0);
    rd_chk(SST_IDX_FLAGS, 32'h84);
    rd_chk(SST_IDX_ISTAT, 32'h0);
    rd_chk(SST_IDX_IMASK, 32'h0);
    // Unmapped word answers with an error and no data
    apb(1'b0, 16'hFFAF, 32'h0, rd, err);
    check({31'h0, err}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    // Flags ignore ones and clear on zeros
    wr(SST_IDX_FLAGS, 32'hFF);
    rd_chk(SST_IDX_FLAGS, 32'h84);
    wr(SST_IDX_FLAGS, 32'h80);
    rd_chk(SST_IDX_FLAGS, 32'h80);
    // Byte waits while transmit is off or clock select is not external
    wr(SST_IDX_HOLD, 32'hA5);
    rd_chk(SST_IDX_HOLD, 32'hA5);
    wr(SST_IDX_CTRL, 32'h23);
    repeat (4) @(posedge pclk);
    rd_chk(SST_IDX_CTRL, 32'h23);
    rd_chk(SST_IDX_FLAGS, 32'h0);
    wr(SST_IDX_FLAGS, 32'hFF);
    rd_chk(SST_IDX_FLAGS, 32'h0);
    wr(SST_IDX_IMASK, 32'h3);
    wr(SST_IDX_CTRL, 32'h20);
    repeat (4) @(posedge pclk);
    rd_chk(SST_IDX_FLAGS, 32'h80);
    u_master.run_frame(8);
    check({24'h0, rx_byte}, 32'hA5, "first char");
    repeat (10) @(posedge pclk);
    rd_chk(SST_IDX_FLAGS, 32'h84);
    check({31'h0, irq}, 32'h1, "irq raised");
    rd_chk(SST_IDX_ISTAT, 32'h3);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    // Back to back characters with interrupts masked
    wr(SST_IDX_IMASK, 32'h0);
    wr(SST_IDX_HOLD, 32'h3C);
    repeat (4) @(posedge pclk);
    rd_chk(SST_IDX_FLAGS, 32'h80);
    wr(SST_IDX_HOLD, 32'hC3);
    rd_chk(SST_IDX_FLAGS, 32'h0);
    u_master.run_frame(8);
    check({24'h0, rx_byte}, 32'h3C, "second char");
    repeat (20) @(posedge pclk);
    rd_chk(SST_IDX_FLAGS, 32'h80);
    u_master.run_frame(8);
    check({24'h0, rx_byte}, 32'hC3, "third char");
    repeat (10) @(posedge pclk);
    rd_chk(SST_IDX_FLAGS, 32'h84);
    check({31'h0, irq}, 32'h0, "masked irq");
    rd_chk(SST_IDX_ISTAT, 32'h3);
    // Dropping transmit enable mid character forces the line high
    wr(SST_IDX_HOLD, 32'h5A);
    repeat (4) @(posedge pclk);
    u_master.run_frame(3);
    repeat (4) @(posedge pclk);
    check({31'h0, serial_out_pin}, 32'h0, "bit two out");
    wr(SST_IDX_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    check({31'h0, serial_out_pin}, 32'h1, "aborted line");
    // Empty flag clears on a written zero once nothing can move
    wr(SST_IDX_FLAGS, 32'h0);
    rd_chk(SST_IDX_FLAGS, 32'h0);
    finish_test();
  end
endmodule : tb
`default_nettype wire
